// *** l2fe_engine.sv ***
// Layer-2 learning, forwarding, port negotiation and reset-button logic.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Learn each good frame's source address and port.
// - Look up destination address to find port.
// - Unknown destination: flood all ports except ingress.
// - Known on another port: send there only.
// - Known on ingress port: drop the frame.
// - Store whole frame, check errors, then send.
// - Negotiate best common speed and duplex.
// - Gigabit links are always full duplex.
// - Detect crossover and swap pairs per port.
// - Five-second button press reboots, restores defaults.
module l2fe_engine #(
    parameter int BTN_HOLD_CYC  = l2fe_pkg::BTN_HOLD_CYC,  // Cycles the button must be held.
    parameter int MDIX_SLOT_CYC = l2fe_pkg::MDIX_SLOT_CYC  // Cycles per pair-layout trial.
) (
    input  wire logic                            i_clk,
    input  wire logic                            i_rst_n,
    input  wire logic                            i_rx_valid,
    input  wire logic [7:0]                      i_rx_data,
    input  wire logic                            i_rx_last,
    input  wire logic                            i_rx_err,
    input  wire logic [l2fe_pkg::PW-1:0]         i_rx_port,
    output logic                                 o_rx_ready,
    output logic                                 o_tx_valid,
    output logic [7:0]                           o_tx_data,
    output logic                                 o_tx_last,
    output logic [l2fe_pkg::NPORT-1:0]           o_tx_port_mask,
    input  wire logic                            i_tx_ready,
    input  wire logic [l2fe_pkg::NPORT-1:0]      i_link_up,
    input  wire logic [l2fe_pkg::NPORT*6-1:0]    i_partner_abil,
    output logic [l2fe_pkg::NPORT*2-1:0]         o_speed,
    output logic [l2fe_pkg::NPORT-1:0]           o_full_duplex,
    output logic [l2fe_pkg::NPORT-1:0]           o_mdix,
    input  wire logic                            i_reset_btn_n,
    input  wire logic                            i_set_ip,
    input  wire logic [31:0]                     i_new_ip,
    output logic [31:0]                          o_mgmt_ip,
    output logic                                 o_reboot,
    output logic                                 o_restore_defaults
);
    // Every register of the block except the frame store lives in this one record.
    typedef struct packed {
        l2fe_pkg::l2fe_state_t                          st;        // Frame handling state.
        logic [11:0]                                    len;       // Bytes stored so far.
        logic [11:0]                                    rd;        // Next byte to send.
        logic                                           bad;       // Frame failed a check.
        logic [47:0]                                    dst;       // Destination address.
        logic [47:0]                                    src;       // Source address.
        logic [l2fe_pkg::PW-1:0]                        in_port;   // Ingress port.
        logic [l2fe_pkg::NPORT-1:0]                     mask;      // Egress ports of this frame.
        logic [l2fe_pkg::NENT-1:0]                      tv;        // Entry holds an address.
        logic [l2fe_pkg::NENT-1:0][47:0]                tmac;      // Learned addresses.
        logic [l2fe_pkg::NENT-1:0][l2fe_pkg::PW-1:0]    tport;     // Learned ports.
        logic [l2fe_pkg::EW-1:0]                        repl;      // Next entry to replace.
        logic [1:0]                                     cnt;       // Words in output buffer.
        l2fe_pkg::l2fe_word_t                           b0;        // Head of output buffer.
        l2fe_pkg::l2fe_word_t                           b1;        // Second word of buffer.
        logic [l2fe_pkg::NPORT-1:0]                     link_q;    // Link level last cycle.
        logic [l2fe_pkg::NPORT*2-1:0]                   spd;       // Resolved speeds.
        logic [l2fe_pkg::NPORT-1:0]                     fdx;       // Resolved duplex.
        logic [l2fe_pkg::NPORT-1:0]                     mdix;      // Pairs swapped.
        logic [13:0]                                    slot;      // Pair-trial timer.
        logic [25:0]                                    btn;       // Button hold timer.
        logic                                           btn_done;  // Hold already acted on.
        logic [31:0]                                    ip;        // Management address.
        logic                                           reboot;    // Reboot pulse.
    } l2fe_regs_t;

    l2fe_regs_t r_reg;     // Current state.
    l2fe_regs_t r_next;    // Next state.

    logic [7:0] mem [0:l2fe_pkg::BUF_DEPTH-1]; // Frame store.
    logic       wr_en;                         // Write a received byte.
    logic [7:0] rd_byte;                       // Byte at the read pointer.

    assign rd_byte = mem[r_reg.rd[l2fe_pkg::BUF_AW-1:0]];

    // Resolve the best common mode; gigabit half duplex is never chosen.
    function automatic logic [2:0] resolve(input logic [5:0] ab);
        logic [5:0] c;
        c = ab & l2fe_pkg::LOCAL_ABIL;
        if (c[l2fe_pkg::AB_1000F]) begin
            resolve = {l2fe_pkg::SPD_1000, 1'b1};
        end else if (c[l2fe_pkg::AB_100F]) begin
            resolve = {l2fe_pkg::SPD_100, 1'b1};
        end else if (c[l2fe_pkg::AB_100H]) begin
            resolve = {l2fe_pkg::SPD_100, 1'b0};
        end else if (c[l2fe_pkg::AB_10F]) begin
            resolve = {l2fe_pkg::SPD_10, 1'b1};
        end else begin
            resolve = {l2fe_pkg::SPD_10, 1'b0};
        end
    endfunction : resolve

    // Receive is open only while no frame waits for its decision or sending.
    assign o_rx_ready = (r_reg.st == l2fe_pkg::ST_RX);
    assign wr_en      = o_rx_ready && i_rx_valid && (r_reg.len < 12'(l2fe_pkg::BUF_DEPTH));

    // Handshake, data and status outputs; transmit data comes from the buffer registers.
    assign o_tx_valid         = (r_reg.cnt != 2'h0);
    assign o_tx_data          = r_reg.b0.data;
    assign o_tx_last          = r_reg.b0.last;
    assign o_tx_port_mask     = r_reg.b0.mask;
    assign o_speed            = r_reg.spd;
    assign o_full_duplex      = r_reg.fdx;
    assign o_mdix             = r_reg.mdix;
    assign o_mgmt_ip          = r_reg.ip;
    assign o_reboot           = r_reg.reboot;
    assign o_restore_defaults = r_reg.reboot;

    // Next-state logic for the whole block.
    always_comb begin
        logic                     s_hit;
        logic                     d_hit;
        logic [l2fe_pkg::EW-1:0]  s_idx;
        logic [l2fe_pkg::PW-1:0]  d_port;
        logic                     pop;
        logic                     push;
        logic [1:0]               c;
        logic                     tick;
        logic [2:0]               res;
        l2fe_pkg::l2fe_word_t     w;
        s_hit  = 1'b0;
        d_hit  = 1'b0;
        s_idx  = r_reg.repl;
        d_port = '0;
        pop    = 1'b0;
        push   = 1'b0;
        c      = 2'h0;
        tick   = 1'b0;
        res    = 3'h0;
        w      = '0;
        r_next = r_reg;
        r_next.reboot = 1'b0;

        // Table search for source and destination of the stored frame.
        for (int i = 0; i < l2fe_pkg::NENT; i++) begin
            if (r_reg.tv[i] && r_reg.tmac[i] == r_reg.src) begin
                s_hit = 1'b1;
                s_idx = l2fe_pkg::EW'(i);
            end
            if (r_reg.tv[i] && r_reg.tmac[i] == r_reg.dst) begin
                d_hit  = 1'b1;
                d_port = r_reg.tport[i];
            end
        end

        unique case (r_reg.st)
            // Collect a frame, capture its header, note any fault.
            l2fe_pkg::ST_RX: begin
                if (i_rx_valid) begin
                    r_next.len = r_reg.len + 12'h001;
                    if (r_reg.len < l2fe_pkg::DST_END) begin
                        r_next.dst = {r_reg.dst[39:0], i_rx_data};
                    end else if (r_reg.len < l2fe_pkg::HDR_LEN) begin
                        r_next.src = {r_reg.src[39:0], i_rx_data};
                    end
                    if (i_rx_err || !wr_en) begin
                        r_next.bad = 1'b1;
                    end
                    r_next.in_port = i_rx_port;
                    if (i_rx_last) begin
                        r_next.st = l2fe_pkg::ST_DECIDE;
                    end
                end
            end
            // Whole frame is in: drop it if faulty, else learn and route it.
            l2fe_pkg::ST_DECIDE: begin
                r_next.rd = 12'h000;
                r_next.st = l2fe_pkg::ST_RX;
                if (r_reg.bad || r_reg.len < l2fe_pkg::HDR_LEN) begin
                    r_next.len = 12'h000;
                    r_next.bad = 1'b0;
                end else begin
                    r_next.tv[s_idx]    = 1'b1;
                    r_next.tmac[s_idx]  = r_reg.src;
                    r_next.tport[s_idx] = r_reg.in_port;
                    if (!s_hit) begin
                        r_next.repl = r_reg.repl + 3'h1;
                    end
                    if (!d_hit) begin
                        r_next.mask = ~(4'h1 << r_reg.in_port);
                        r_next.st   = l2fe_pkg::ST_TX;
                    end else if (d_port != r_reg.in_port) begin
                        r_next.mask = 4'h1 << d_port;
                        r_next.st   = l2fe_pkg::ST_TX;
                    end else begin
                        r_next.len = 12'h000;
                    end
                end
            end
            // Sending starts only after the checks above; push one byte per free slot.
            l2fe_pkg::ST_TX: begin
                push = (r_reg.cnt != 2'h2) || i_tx_ready;
                w    = '{mask: r_reg.mask, last: (r_reg.rd == r_reg.len - 12'h001), data: rd_byte};
                if (push) begin
                    r_next.rd = r_reg.rd + 12'h001;
                    if (w.last) begin
                        r_next.st  = l2fe_pkg::ST_RX;
                        r_next.len = 12'h000;
                    end
                end
            end
        endcase

        // Two-entry output buffer; a stalled receiver holds words, none is lost.
        pop = o_tx_valid && i_tx_ready;
        c   = r_reg.cnt;
        if (pop) begin
            r_next.b0 = r_reg.b1;
            c         = c - 2'h1;
        end
        if (push) begin
            if (c == 2'h0) begin
                r_next.b0 = w;
            end else begin
                r_next.b1 = w;
            end
            c = c + 2'h1;
        end
        r_next.cnt = c;

        // Pair-trial timer shared by all ports.
        tick = (r_reg.slot == 14'(MDIX_SLOT_CYC - 1));
        r_next.slot = tick ? 14'h0000 : r_reg.slot + 14'h0001;

        // Per port: resolve mode when link comes up, alternate pairs while down.
        r_next.link_q = i_link_up;
        for (int p = 0; p < l2fe_pkg::NPORT; p++) begin
            if (i_link_up[p] && !r_reg.link_q[p]) begin
                res = resolve(i_partner_abil[p*6 +: 6]);
                r_next.spd[p*2 +: 2] = res[2:1];
                r_next.fdx[p]        = res[0];
            end
            if (!i_link_up[p] && tick) begin
                r_next.mdix[p] = ~r_reg.mdix[p];
            end
        end

        // Management address may be set; a long button press restores it.
        if (i_set_ip) begin
            r_next.ip = i_new_ip;
        end
        if (i_reset_btn_n) begin
            r_next.btn      = 26'h0000000;
            r_next.btn_done = 1'b0;
        end else if (!r_reg.btn_done) begin
            if (r_reg.btn == 26'(BTN_HOLD_CYC - 1)) begin
                r_next.btn_done = 1'b1;
                r_next.reboot   = 1'b1;
                r_next.ip       = l2fe_pkg::DEF_IP;
            end else begin
                r_next.btn = r_reg.btn + 26'h0000001;
            end
        end
    end

    // State register with asynchronous reset to constants.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg    <= '0;
            r_reg.st <= l2fe_pkg::ST_RX;
            r_reg.ip <= l2fe_pkg::DEF_IP;
        end else begin
            r_reg <= r_next;
        end
    end

    // Frame store write port.
    always_ff @(posedge i_clk) begin
        if (wr_en) begin
            mem[r_reg.len[l2fe_pkg::BUF_AW-1:0]] <= i_rx_data;
        end
    end
endmodule : l2fe_engine

`default_nettype wire

// *** l2fe_pkg.sv ***
// Shared constants and types of the layer-2 learning and forwarding engine.
package l2fe_pkg;
    localparam int          NPORT        = 4;                  // Number of switch ports.
    localparam int          PW           = 2;                  // Width of a port number.
    localparam int          NENT         = 8;                  // Entries in the address table.
    localparam int          EW           = 3;                  // Width of an entry index.
    localparam int          BUF_AW       = 11;                 // Address width of the frame store.
    localparam int          BUF_DEPTH    = 2048;               // Bytes in the frame store.
    localparam logic [11:0] HDR_LEN      = 12'h00C;            // Bytes of destination plus source.
    localparam logic [11:0] DST_END      = 12'h006;            // First byte after the destination.
    localparam int          CLK_HZ       = 10_000_000;         // Core clock rate.
    localparam int          BTN_HOLD_S   = 5;                  // Button hold time in seconds.
    localparam int          BTN_HOLD_CYC = CLK_HZ * BTN_HOLD_S; // Button hold time in cycles.
    localparam int          MDIX_SLOT_NS = 1_000_000;          // Dwell on one pair layout, in ns.
    localparam int          MDIX_SLOT_CYC = MDIX_SLOT_NS / (1_000_000_000 / CLK_HZ); // Dwell in cycles.
    localparam logic [31:0] DEF_IP       = 32'hC0A8_0064;      // Default management address.
    // Ability bit positions, as seen in local and partner ability words.
    localparam int          AB_10H       = 0;
    localparam int          AB_10F       = 1;
    localparam int          AB_100H      = 2;
    localparam int          AB_100F      = 3;
    localparam int          AB_1000H     = 4;
    localparam int          AB_1000F     = 5;
    localparam logic [5:0]  LOCAL_ABIL   = 6'h3F;              // This end offers every mode.
    // Speed codes.
    localparam logic [1:0]  SPD_10       = 2'h0;
    localparam logic [1:0]  SPD_100      = 2'h1;
    localparam logic [1:0]  SPD_1000     = 2'h2;

    // Frame handling states.
    typedef enum logic [2:0] {
        ST_RX     = 3'b001,
        ST_DECIDE = 3'b010,
        ST_TX     = 3'b100
    } l2fe_state_t;

    // One entry of the output buffer: port mask, last flag, byte.
    typedef struct packed {
        logic [NPORT-1:0] mask;
        logic             last;
        logic [7:0]       data;
    } l2fe_word_t;
endpackage : l2fe_pkg

// *** l2fe_chk.sv ***
// Concurrent checks on the forwarding engine's ports.
`timescale 1ns/100ps
`default_nettype none
module l2fe_chk #(
    parameter int BTN_HOLD_CYC  = 20, // Cycles the button must be held.
    parameter int MDIX_SLOT_CYC = 8   // Cycles per pair-layout trial.
) (
    input wire logic                         i_clk,
    input wire logic                         i_rst_n,
    input wire logic                         i_rx_valid,
    input wire logic                         i_rx_last,
    input wire logic                         o_rx_ready,
    input wire logic                         o_tx_valid,
    input wire logic [7:0]                   o_tx_data,
    input wire logic                         o_tx_last,
    input wire logic [l2fe_pkg::NPORT-1:0]   o_tx_port_mask,
    input wire logic                         i_tx_ready,
    input wire logic [l2fe_pkg::NPORT-1:0]   i_link_up,
    input wire logic [l2fe_pkg::NPORT*6-1:0] i_partner_abil,
    input wire logic [l2fe_pkg::NPORT*2-1:0] o_speed,
    input wire logic [l2fe_pkg::NPORT-1:0]   o_full_duplex,
    input wire logic [l2fe_pkg::NPORT-1:0]   o_mdix,
    input wire logic                         i_reset_btn_n,
    input wire logic [31:0]                  o_mgmt_ip,
    input wire logic                         o_reboot,
    input wire logic                         o_restore_defaults
);
    int   hold_cnt; // Cycles the button has been held down.
    int   mdix_age; // Cycles since port 0 last swapped its pairs.
    logic mdix_q;   // Pair layout of port 0 one cycle ago.
    logic gig_half; // Some port runs gigabit at half duplex.

    // Best common mode as {speed, full duplex}; gigabit half is never taken.
    function automatic logic [2:0] best(input logic [5:0] a);
        logic [5:0] c;
        c = a & l2fe_pkg::LOCAL_ABIL;
        if (c[l2fe_pkg::AB_1000F]) return {l2fe_pkg::SPD_1000, 1'b1};
        if (c[l2fe_pkg::AB_100F]) return {l2fe_pkg::SPD_100, 1'b1};
        if (c[l2fe_pkg::AB_100H]) return {l2fe_pkg::SPD_100, 1'b0};
        if (c[l2fe_pkg::AB_10F]) return {l2fe_pkg::SPD_10, 1'b1};
        return {l2fe_pkg::SPD_10, 1'b0};
    endfunction : best

    // Count the button hold and the dwell of port 0 on one pair layout.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_cnt <= 0;
            mdix_age <= 0;
            mdix_q   <= 1'b0;
        end else begin
            hold_cnt <= i_reset_btn_n ? 0 : hold_cnt + 1;
            mdix_age <= (i_link_up[0] || o_mdix[0] != mdix_q) ? 0 : mdix_age + 1;
            mdix_q   <= o_mdix[0];
        end
    end

    // Flag any port that reports gigabit without full duplex.
    always_comb begin
        gig_half = 1'b0;
        for (int p = 0; p < l2fe_pkg::NPORT; p++) begin
            gig_half |= o_speed[2*p +: 2] == l2fe_pkg::SPD_1000 && !o_full_duplex[p];
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_frame_end;
        i_rx_valid && o_rx_ready && i_rx_last;
    endsequence
    sequence s_tx_stall;
        o_tx_valid && !i_tx_ready;
    endsequence

    chk_gig_full: assert property (!gig_half)
        else $error("gigabit link reported at half duplex");
    chk_rx_pause: assert property (s_frame_end |=> !o_rx_ready)
        else $error("receive not paused after frame end");
    chk_tx_hold: assert property (s_tx_stall |=> o_tx_valid && $stable({o_tx_data, o_tx_last, o_tx_port_mask}))
        else $error("output word changed while stalled");
    chk_tx_after_store: assert property ($rose(o_tx_valid) |-> !o_rx_ready)
        else $error("output started while a frame was still arriving");
    chk_neg_best: assert property ($rose(i_link_up[0]) |=> {o_speed[1:0], o_full_duplex[0]} == best(i_partner_abil[5:0]))
        else $error("port 0 did not settle on the best common mode");
    chk_mdix_hunt: assert property (!i_link_up[0] |-> mdix_age <= MDIX_SLOT_CYC)
        else $error("port 0 kept one pair layout too long");
    chk_btn_hold: assert property ($rose(o_reboot) |-> hold_cnt >= BTN_HOLD_CYC - 2 && hold_cnt <= BTN_HOLD_CYC + 1)
        else $error("reboot after wrong hold time");
    chk_reboot_pulse: assert property (o_reboot |-> o_restore_defaults && o_mgmt_ip == l2fe_pkg::DEF_IP ##1 !o_reboot)
        else $error("reboot pulse malformed");
endmodule : l2fe_chk

bind l2fe_engine l2fe_chk #(.BTN_HOLD_CYC(BTN_HOLD_CYC), .MDIX_SLOT_CYC(MDIX_SLOT_CYC)) u_chk (
    .i_clk, .i_rst_n, .i_rx_valid, .i_rx_last, .o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_last,
    .o_tx_port_mask, .i_tx_ready, .i_link_up, .i_partner_abil, .o_speed, .o_full_duplex, .o_mdix,
    .i_reset_btn_n, .o_mgmt_ip, .o_reboot, .o_restore_defaults);
`default_nettype wire

// *** l2fe_sink.sv ***
// Model of the receiving ports that take the engine's output words.
`timescale 1ns/100ps
`default_nettype none
module l2fe_sink (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_slow,
    input  wire logic                       i_valid,
    input  wire logic [7:0]                 i_data,
    input  wire logic                       i_last,
    input  wire logic [l2fe_pkg::NPORT-1:0] i_mask,
    output var  logic                       o_ready
);
    l2fe_pkg::l2fe_word_t got[$]; // Words taken so far.
    logic [1:0]           phase;  // Position in the stall pattern.

    // Slow mode takes one word in three, so the two-entry buffer fills.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase   <= 2'h0;
            o_ready <= 1'b0;
        end else begin
            phase   <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            o_ready <= !i_slow || phase == 2'h1;
            if (i_valid && o_ready) begin
                got.push_back({i_mask, i_last, i_data});
            end
        end
    end
endmodule : l2fe_sink
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench of the forwarding engine.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        i_clk, i_rst_n, rx_valid, rx_last, rx_err, rx_ready, tx_valid, tx_last, tx_ready;
    logic        slow, btn_n, set_ip, reboot, restore;
    logic [7:0]  rx_data, tx_data;
    logic [1:0]  rx_port;
    logic [3:0]  tx_mask, link_up, fd, mdix;
    logic [23:0] abil;
    logic [7:0]  speed;
    logic [31:0] new_ip, mgmt_ip;
    int          n_errors, checks_done, cyc, n_pulse;

    l2fe_engine #(.BTN_HOLD_CYC(20), .MDIX_SLOT_CYC(8)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_err(rx_err),
        .i_rx_port(rx_port), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
        .o_tx_last(tx_last), .o_tx_port_mask(tx_mask), .i_tx_ready(tx_ready), .i_link_up(link_up),
        .i_partner_abil(abil), .o_speed(speed), .o_full_duplex(fd), .o_mdix(mdix),
        .i_reset_btn_n(btn_n), .i_set_ip(set_ip), .i_new_ip(new_ip), .o_mgmt_ip(mgmt_ip),
        .o_reboot(reboot), .o_restore_defaults(restore));
    l2fe_sink u_sink (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow), .i_valid(tx_valid),
        .i_data(tx_data), .i_last(tx_last), .i_mask(tx_mask), .o_ready(tx_ready));

    // Clock, cycle ceiling and reboot pulse count.
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (reboot === 1'b1) n_pulse++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
            n_errors++;
        end
    endtask : check

    // Send one 14-byte frame, let it drain, and compare what came out.
    task automatic frame(input logic [1:0] port, input logic [47:0] dst, src, input logic err, input logic [3:0] mask);
        logic [111:0] fr;
        int           n;
        fr = {dst, src, 16'hA5C3};
        u_sink.got.delete();
        for (int i = 0; i < 14; i++) begin
            @(negedge i_clk);
            rx_valid = 1'b1;
            rx_data  = fr[111-8*i -: 8];
            rx_last  = i == 13;
            rx_err   = err && i == 7;
            rx_port  = port;
            while (!rx_ready) @(negedge i_clk);
            @(posedge i_clk);
        end
        @(negedge i_clk);
        rx_valid = 1'b0;
        rx_last  = 1'b0;
        rx_err   = 1'b0;
        n = 0;
        while (n < 200 && !(rx_ready && !tx_valid)) begin
            @(negedge i_clk);
            n++;
        end
        check("drained", 64'h1, n < 200);
        check("word count", (mask == 4'h0) ? 64'h0 : 64'hE, u_sink.got.size());
        foreach (u_sink.got[i]) check("word", {mask, i == 13, fr[111-8*i -: 8]}, u_sink.got[i]);
    endtask : frame

    // Hunt pairs with port 0 down, then bring it up against the given partner.
    task automatic neg(input logic [5:0] a, input logic [2:0] exp);
        logic m;
        int   n;
        @(negedge i_clk);
        link_up[0] = 1'b0;
        abil[5:0]  = a;
        m = mdix[0];
        n = 0;
        while (mdix[0] === m && n < 10) begin
            @(negedge i_clk);
            n++;
        end
        check("pair swap", 64'h1, mdix[0] !== m);
        link_up[0] = 1'b1;
        repeat (2) @(negedge i_clk);
        check("speed duplex", exp, {speed[1:0], fd[0]});
    endtask : neg

    // Management address write, short press, then a full-length press.
    task automatic button();
        @(negedge i_clk);
        set_ip = 1'b1;
        new_ip = 32'h0A00_0001;
        @(negedge i_clk);
        set_ip = 1'b0;
        btn_n  = 1'b0;
        repeat (10) @(negedge i_clk);
        btn_n = 1'b1;
        check("ip after short press", 32'h0A00_0001, mgmt_ip);
        @(negedge i_clk);
        btn_n = 1'b0;
        repeat (30) @(negedge i_clk);
        btn_n = 1'b1;
        check("reboot pulses", 64'h1, n_pulse);
        check("ip restored", l2fe_pkg::DEF_IP, mgmt_ip);
    endtask : button

    // Main sequence.
    initial begin
        {i_rst_n, rx_valid, rx_last, rx_err, set_ip} = '0;
        {rx_data, rx_port, new_ip} = '0;
        {slow, btn_n, link_up, abil} = {2'h3, 4'h0, 24'hFFFFFF};
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        link_up = 4'hF;
        frame(2'h0, 48'hB2, 48'hA1, 1'b0, 4'hE);
        slow = 1'b0;
        frame(2'h2, 48'hA1, 48'hC3, 1'b0, 4'h1);
        slow = 1'b1;
        frame(2'h0, 48'hA1, 48'hD4, 1'b0, 4'h0);
        frame(2'h2, 48'hA1, 48'hC3, 1'b1, 4'h0);
        frame(2'h3, 48'hC3, 48'hA1, 1'b0, 4'h4);
        frame(2'h1, 48'hA1, 48'hC3, 1'b0, 4'h8);
        neg(6'h3F, {l2fe_pkg::SPD_1000, 1'b1});
        neg(6'h18, {l2fe_pkg::SPD_100, 1'b1});
        neg(6'h04, {l2fe_pkg::SPD_100, 1'b0});
        neg(6'h02, {l2fe_pkg::SPD_10, 1'b1});
        neg(6'h00, {l2fe_pkg::SPD_10, 1'b0});
        button();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
